// ===== pkg/ccx_pkg.sv
package ccx_pkg;
  localparam logic [7:0] OP_RETURN_NEAR     = 8'hc3;
  localparam logic [7:0] OP_RETURN_NEAR_IMM = 8'hc2;
  localparam logic [7:0] OP_RETURN_FAR      = 8'hcb;
  localparam logic [7:0] OP_RETURN_FAR_IMM  = 8'hca;
  localparam logic [3:0] OP_JCC_HIGH        = 4'h7;
  localparam logic [7:0] OP_JUMP_COUNT_ZERO = 8'he3;
  localparam logic [7:0] OP_LOOP_COUNT      = 8'he2;
  localparam logic [7:0] OP_LOOP_ZERO       = 8'he1;
  localparam logic [7:0] OP_LOOP_NOT_ZERO   = 8'he0;
  localparam logic [7:0] OP_ENTER           = 8'hc8;
  localparam logic [7:0] OP_LEAVE           = 8'hc9;
  localparam logic [7:0] OP_SOFT_INT        = 8'hcd;
  localparam logic [7:0] OP_BREAKPOINT      = 8'hcc;
  localparam logic [7:0] OP_OVERFLOW_TRAP   = 8'hce;
  localparam logic [7:0] OP_INT_RETURN      = 8'hcf;
  localparam logic [7:0] OP_BOUND           = 8'h62;
  localparam logic [7:0] OP_CARRY_CLEAR     = 8'hf8;
  localparam logic [7:0] OP_CARRY_COMPL     = 8'hf5;
  localparam logic [7:0] OP_CARRY_SET       = 8'hf9;
  localparam logic [7:0] OP_DIR_CLEAR       = 8'hfc;
  localparam logic [7:0] OP_DIR_SET         = 8'hfd;
  localparam logic [7:0] OP_IE_CLEAR        = 8'hfa;
  localparam logic [7:0] OP_IE_SET          = 8'hfb;
  localparam logic [7:0] OP_HALT            = 8'hf4;
  localparam logic [7:0] OP_LOCK            = 8'hf0;
  localparam logic [4:0] OP_ESCAPE_HIGH     = 5'h1b;
  localparam logic [2:0] SEG_PFX_TOP        = 3'h1;
  localparam logic [2:0] SEG_PFX_LOW        = 3'h6;
  localparam logic [7:0] BREAKPOINT_VECTOR  = 8'h03;

  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE  = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA  = 2'h3;

  // cycle costs; where a pair depends on the bus, 16-bit bus then 8-bit bus
  localparam logic [15:0] CYC_RN_16 = 16'h0010, CYC_RN_8 = 16'h0014;
  localparam logic [15:0] CYC_RNI_16 = 16'h0012, CYC_RNI_8 = 16'h0016;
  localparam logic [15:0] CYC_RF_16 = 16'h0016, CYC_RF_8 = 16'h001e;
  localparam logic [15:0] CYC_RFI_16 = 16'h0019, CYC_RFI_8 = 16'h0021;
  localparam logic [15:0] CYC_JCC_NT = 16'h0004, CYC_JCC_T = 16'h000d;
  localparam logic [15:0] CYC_JCZ_NT = 16'h0005, CYC_JCZ_T = 16'h000f;
  localparam logic [15:0] CYC_LOOP_NT = 16'h0006, CYC_LOOP_T = 16'h0010;
  localparam logic [15:0] CYC_EN0_16 = 16'h000f, CYC_EN0_8 = 16'h0013;
  localparam logic [15:0] CYC_EN1_16 = 16'h0019, CYC_EN1_8 = 16'h001d;
  localparam logic [15:0] CYC_ENN_16 = 16'h0016, CYC_ENN_8 = 16'h001a;
  localparam logic [15:0] CYC_ENS_16 = 16'h0010, CYC_ENS_8 = 16'h0014;
  localparam logic [15:0] CYC_LEAVE = 16'h0008;
  localparam logic [15:0] CYC_SOFT_INT = 16'h002f, CYC_BREAKPOINT = 16'h002d;
  localparam logic [15:0] CYC_OVF_T = 16'h0030, CYC_OVF_NT = 16'h0004;
  localparam logic [15:0] CYC_INT_RETURN = 16'h001c;
  localparam logic [15:0] CYC_BOUND = 16'h0023;
  localparam logic [15:0] CYC_FLAG_OP = 16'h0002, CYC_HALT = 16'h0002;
  localparam logic [15:0] CYC_LOCK_16 = 16'h0002, CYC_LOCK_8 = 16'h0003;
  localparam logic [15:0] CYC_ESCAPE = 16'h0006;

  typedef enum logic [2:0] {
    ST_OPCODE, ST_MODE, ST_DISP_LO, ST_DISP_HI, ST_IMM_LO, ST_IMM_HI, ST_LEVEL
  } ccx_state_type;

  typedef enum logic [4:0] {
    CL_NONE, CL_RETURN_NEAR, CL_RETURN_NEAR_IMM, CL_RETURN_FAR, CL_RETURN_FAR_IMM,
    CL_JCC, CL_JUMP_COUNT_ZERO, CL_LOOP, CL_LOOP_Z, CL_LOOP_NZ, CL_ENTER, CL_LEAVE,
    CL_SOFT_INT, CL_BREAKPOINT, CL_OVERFLOW_TRAP, CL_INT_RETURN, CL_BOUND,
    CL_CARRY_CLEAR, CL_CARRY_COMPL, CL_CARRY_SET, CL_DIR_CLEAR, CL_DIR_SET,
    CL_IE_CLEAR, CL_IE_SET, CL_HALT, CL_COPROC_ESCAPE, CL_UNKNOWN
  } ccx_class_type;
endpackage : ccx_pkg

// ===== verilog/ccx_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module ccx_decoder #(
  parameter logic [7:0] OVF_VECTOR = 8'h04
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_rstn,
  input  wire logic [7:0]             i_byte,
  input  wire logic                   i_byte_valid,
  input  wire logic                   i_bus8,
  input  wire logic                   i_word_op,
  input  wire logic                   i_string_dest,
  input  wire logic [3:0]             i_mem_xfers,
  input  wire logic                   i_carry,
  input  wire logic                   i_zero,
  input  wire logic                   i_sign,
  input  wire logic                   i_overflow,
  input  wire logic                   i_parity,
  input  wire logic [15:0]            i_count,
  input  wire logic [15:0]            i_base,
  input  wire logic [15:0]            i_src_idx,
  input  wire logic [15:0]            i_dst_idx,
  input  wire logic [15:0]            i_frame,
  output logic                        o_valid,
  output ccx_pkg::ccx_class_type      o_class,
  output logic [15:0]                 o_cycles,
  output logic                        o_taken,
  output logic [15:0]                 o_disp,
  output logic [15:0]                 o_imm,
  output logic [7:0]                  o_level,
  output logic [7:0]                  o_int_vector,
  output logic [15:0]                 o_eff_addr,
  output logic                        o_eff_addr_valid,
  output logic [1:0]                  o_seg,
  output logic                        o_lock,
  output logic [5:0]                  o_escape_code,
  output logic [2:0]                  o_reg_idx,
  output logic                        o_reg_high,
  output logic                        o_rm_is_reg
);
  import ccx_pkg::*;

  typedef struct packed {
    ccx_state_type st;
    logic [7:0]    op;
    logic [7:0]    mode;
    logic [15:0]   disp;
    logic [15:0]   imm;
    logic          ovr_v;
    logic [1:0]    ovr_seg;
    logic          lock_p;
    logic [15:0]   pfx_cyc;
    logic          valid;
    ccx_class_type cls;
    logic [15:0]   cycles;
    logic          taken;
    logic [7:0]    level;
    logic [7:0]    vector;
    logic [15:0]   ea;
    logic          ea_v;
    logic [1:0]    seg;
    logic          lock;
    logic [5:0]    coprocessor_escape_op;
    logic [2:0]    reg_idx;
    logic          reg_high;
    logic          rm_reg;
  } ccx_regs_type;

  ccx_regs_type q, d;

  function automatic ccx_class_type classify(input logic [7:0] op);
    if (op[7:4] == OP_JCC_HIGH) return CL_JCC;
    if (op[7:3] == OP_ESCAPE_HIGH) return CL_COPROC_ESCAPE;
    case (op)
      OP_RETURN_NEAR:     return CL_RETURN_NEAR;
      OP_RETURN_NEAR_IMM: return CL_RETURN_NEAR_IMM;
      OP_RETURN_FAR:      return CL_RETURN_FAR;
      OP_RETURN_FAR_IMM:  return CL_RETURN_FAR_IMM;
      OP_JUMP_COUNT_ZERO: return CL_JUMP_COUNT_ZERO;
      OP_LOOP_COUNT:      return CL_LOOP;
      OP_LOOP_ZERO:       return CL_LOOP_Z;
      OP_LOOP_NOT_ZERO:   return CL_LOOP_NZ;
      OP_ENTER:           return CL_ENTER;
      OP_LEAVE:           return CL_LEAVE;
      OP_SOFT_INT:        return CL_SOFT_INT;
      OP_BREAKPOINT:      return CL_BREAKPOINT;
      OP_OVERFLOW_TRAP:   return CL_OVERFLOW_TRAP;
      OP_INT_RETURN:      return CL_INT_RETURN;
      OP_BOUND:           return CL_BOUND;
      OP_CARRY_CLEAR:     return CL_CARRY_CLEAR;
      OP_CARRY_COMPL:     return CL_CARRY_COMPL;
      OP_CARRY_SET:       return CL_CARRY_SET;
      OP_DIR_CLEAR:       return CL_DIR_CLEAR;
      OP_DIR_SET:         return CL_DIR_SET;
      OP_IE_CLEAR:        return CL_IE_CLEAR;
      OP_IE_SET:          return CL_IE_SET;
      OP_HALT:            return CL_HALT;
      default:            return CL_UNKNOWN;
    endcase
  endfunction : classify

  // flag condition from the low nibble
  function automatic logic jcc_cond(input logic [3:0] c, input logic cf, input logic zf,
                                    input logic sf, input logic of, input logic pf);
    logic r;
    r = 1'b0;
    case (c[3:1])
      3'h0: r = of;
      3'h1: r = cf;
      3'h2: r = zf;
      3'h3: r = cf | zf;
      3'h4: r = sf;
      3'h5: r = pf;
      3'h6: r = sf ^ of;
      default: r = (sf ^ of) | zf;
    endcase
    return r ^ c[0];
  endfunction : jcc_cond

  function automatic logic [15:0] pick(input logic b8, input logic [15:0] w16,
                                       input logic [15:0] w8);
    return b8 ? w8 : w16;
  endfunction : pick

  ccx_class_type cls_in;
  ccx_class_type cls_f;
  logic          fin;
  logic [7:0]    op_f;
  logic [7:0]    mode_f;
  logic [7:0]    lvl_f;
  logic [15:0]   lvm1;
  logic [15:0]   pen;
  logic          long_disp;
  logic          mem_op;
  logic          tk;
  logic [15:0]   cyc;

  always_comb begin
    d         = q;
    d.valid   = 1'b0;
    fin       = 1'b0;
    lvl_f     = 8'h00;
    cls_in    = classify(i_byte);
    long_disp = (q.mode[7:6] == 2'b10) || (q.mode[7:6] == 2'b00 && q.mode[2:0] == 3'h6);
    case (q.st)
      ST_OPCODE: begin
        if (i_byte_valid) begin
          d.op   = i_byte;
          d.mode = 8'h00;
          d.disp = 16'h0000;
          d.imm  = 16'h0000;
          if (i_byte[7:5] == SEG_PFX_TOP && i_byte[2:0] == SEG_PFX_LOW) begin
            d.ovr_v   = 1'b1;
            d.ovr_seg = i_byte[4:3];
          end else if (i_byte == OP_LOCK) begin
            d.lock_p  = 1'b1;
            d.pfx_cyc = q.pfx_cyc + pick(i_bus8, CYC_LOCK_16, CYC_LOCK_8);
          end else if (cls_in == CL_BOUND || cls_in == CL_COPROC_ESCAPE) begin
            d.st = ST_MODE;
          end else if (cls_in inside {CL_JCC, CL_JUMP_COUNT_ZERO, CL_LOOP, CL_LOOP_Z,
                                      CL_LOOP_NZ}) begin
            d.st = ST_DISP_LO;
          end else if (cls_in inside {CL_RETURN_NEAR_IMM, CL_RETURN_FAR_IMM, CL_ENTER,
                                      CL_SOFT_INT}) begin
            d.st = ST_IMM_LO;
          end else begin
            fin = 1'b1;
          end
        end
      end
      ST_MODE: begin
        if (i_byte_valid) begin
          d.mode = i_byte;
          if (i_byte[7:6] == 2'b01 || i_byte[7:6] == 2'b10 ||
              (i_byte[7:6] == 2'b00 && i_byte[2:0] == 3'h6)) begin
            d.st = ST_DISP_LO;
          end else begin
            fin = 1'b1;
          end
        end
      end
      ST_DISP_LO: begin
        if (i_byte_valid) begin
          d.disp = {{8{i_byte[7]}}, i_byte};
          if (long_disp) d.st = ST_DISP_HI;
          else fin = 1'b1;
        end
      end
      ST_DISP_HI: begin
        if (i_byte_valid) begin
          d.disp[15:8] = i_byte;
          fin = 1'b1;
        end
      end
      ST_IMM_LO: begin
        if (i_byte_valid) begin
          d.imm = {8'h00, i_byte};
          if (q.op == OP_SOFT_INT) fin = 1'b1;
          else d.st = ST_IMM_HI;
        end
      end
      ST_IMM_HI: begin
        if (i_byte_valid) begin
          d.imm[15:8] = i_byte;
          if (q.op == OP_ENTER) d.st = ST_LEVEL;
          else fin = 1'b1;
        end
      end
      ST_LEVEL: begin
        if (i_byte_valid) begin
          lvl_f = i_byte;
          fin = 1'b1;
        end
      end
      default: d.st = ST_OPCODE;
    endcase

    op_f   = (q.st == ST_OPCODE) ? i_byte : q.op;
    mode_f = (q.st == ST_MODE) ? i_byte : q.mode;
    cls_f  = classify(op_f);
    mem_op = (cls_f == CL_BOUND || cls_f == CL_COPROC_ESCAPE) && mode_f[7:6] != 2'b11;
    lvm1   = {8'h00, lvl_f} - 16'h0001;
    pen    = (i_bus8 && i_word_op && mem_op) ? {10'h000, i_mem_xfers, 2'b00} : 16'h0000;
    tk     = 1'b0;
    cyc    = 16'h0000;
    case (cls_f)
      CL_RETURN_NEAR:     cyc = pick(i_bus8, CYC_RN_16, CYC_RN_8);
      CL_RETURN_NEAR_IMM: cyc = pick(i_bus8, CYC_RNI_16, CYC_RNI_8);
      CL_RETURN_FAR:      cyc = pick(i_bus8, CYC_RF_16, CYC_RF_8);
      CL_RETURN_FAR_IMM:  cyc = pick(i_bus8, CYC_RFI_16, CYC_RFI_8);
      CL_JCC: begin
        tk  = jcc_cond(op_f[3:0], i_carry, i_zero, i_sign, i_overflow, i_parity);
        cyc = tk ? CYC_JCC_T : CYC_JCC_NT;
      end
      CL_JUMP_COUNT_ZERO: begin
        tk  = (i_count == 16'h0000);
        cyc = tk ? CYC_JCZ_T : CYC_JCZ_NT;
      end
      CL_LOOP, CL_LOOP_Z, CL_LOOP_NZ: begin
        tk  = (i_count != 16'h0001) && (cls_f == CL_LOOP || (cls_f == CL_LOOP_Z) == i_zero);
        cyc = tk ? CYC_LOOP_T : CYC_LOOP_NT;
      end
      CL_ENTER: begin
        if (lvl_f == 8'h00) cyc = pick(i_bus8, CYC_EN0_16, CYC_EN0_8);
        else if (lvl_f == 8'h01) cyc = pick(i_bus8, CYC_EN1_16, CYC_EN1_8);
        else cyc = pick(i_bus8, CYC_ENN_16, CYC_ENN_8)
                   + 16'(lvm1 * pick(i_bus8, CYC_ENS_16, CYC_ENS_8));
      end
      CL_LEAVE:         cyc = CYC_LEAVE;
      CL_SOFT_INT:      cyc = CYC_SOFT_INT;
      CL_BREAKPOINT:    cyc = CYC_BREAKPOINT;
      CL_OVERFLOW_TRAP: begin
        tk  = i_overflow;
        cyc = tk ? CYC_OVF_T : CYC_OVF_NT;
      end
      CL_INT_RETURN:    cyc = CYC_INT_RETURN;
      CL_BOUND:         cyc = CYC_BOUND + pen;
      CL_CARRY_CLEAR, CL_CARRY_COMPL, CL_CARRY_SET,
      CL_DIR_CLEAR, CL_DIR_SET, CL_IE_CLEAR, CL_IE_SET: cyc = CYC_FLAG_OP;
      CL_HALT:          cyc = CYC_HALT;
      CL_COPROC_ESCAPE: cyc = CYC_ESCAPE + pen;
      default:          cyc = 16'h0000;
    endcase

    if (fin) begin
      d.st       = ST_OPCODE;
      d.valid    = 1'b1;
      d.cls      = cls_f;
      d.cycles   = q.pfx_cyc + cyc;
      d.taken    = tk;
      d.level    = lvl_f;
      d.vector   = (cls_f == CL_BREAKPOINT) ? BREAKPOINT_VECTOR :
                   (cls_f == CL_OVERFLOW_TRAP) ? OVF_VECTOR : d.imm[7:0];
      d.lock     = q.lock_p;
      d.coprocessor_escape_op      = {op_f[2:0], mode_f[5:3]};
      d.rm_reg   = mem_op ? 1'b0 : (mode_f[7:6] == 2'b11);
      d.reg_idx  = i_word_op ? mode_f[5:3] : {1'b0, mode_f[4:3]};
      d.reg_high = !i_word_op && mode_f[5];
      d.ea_v     = mem_op;
      case (mode_f[2:0])
        3'h0: d.ea = i_base + i_src_idx + d.disp;
        3'h1: d.ea = i_base + i_dst_idx + d.disp;
        3'h2: d.ea = i_frame + i_src_idx + d.disp;
        3'h3: d.ea = i_frame + i_dst_idx + d.disp;
        3'h4: d.ea = i_src_idx + d.disp;
        3'h5: d.ea = i_dst_idx + d.disp;
        3'h6: d.ea = (mode_f[7:6] == 2'b00) ? d.disp : i_frame + d.disp;
        default: d.ea = i_base + d.disp;
      endcase
      if (i_string_dest) d.seg = SEG_EXTRA;
      else if (q.ovr_v) d.seg = q.ovr_seg;
      else if (mode_f[2:1] == 2'b01 || (mode_f[2:0] == 3'h6 && mode_f[7:6] != 2'b00))
        d.seg = SEG_STACK;
      else d.seg = SEG_DATA;
      d.ovr_v    = 1'b0;
      d.lock_p   = 1'b0;
      d.pfx_cyc  = 16'h0000;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) q <= '0;
    else q <= d;
  end

  assign o_valid          = q.valid;
  assign o_class          = q.cls;
  assign o_cycles         = q.cycles;
  assign o_taken          = q.taken;
  assign o_disp           = q.disp;
  assign o_imm            = q.imm;
  assign o_level          = q.level;
  assign o_int_vector     = q.vector;
  assign o_eff_addr       = q.ea;
  assign o_eff_addr_valid = q.ea_v;
  assign o_seg            = q.seg;
  assign o_lock           = q.lock;
  assign o_escape_code    = q.coprocessor_escape_op;
  assign o_reg_idx        = q.reg_idx;
  assign o_reg_high       = q.reg_high;
  assign o_rm_is_reg      = q.rm_reg;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  sequence s_opc(logic [7:0] b);
    q.st == ST_OPCODE && i_byte_valid && i_byte == b;
  endsequence
  sequence s_direct_mode;
    q.st == ST_MODE && i_byte_valid && i_byte[7:6] == 2'b00 && i_byte[2:0] == 3'h6;
  endsequence

  ret_near_cost_a: assert property (o_valid && o_class == CL_RETURN_NEAR && !o_lock |->
    o_cycles == ($past(i_bus8) ? CYC_RN_8 : CYC_RN_16)) else $error("near return cost");
  short_jump_cost_a: assert property (o_valid && o_class == CL_JCC |->
    o_cycles == (o_taken ? CYC_JCC_T : CYC_JCC_NT)) else $error("short jump cost");
  count_zero_a: assert property (o_valid && o_class == CL_JUMP_COUNT_ZERO |->
    o_taken == ($past(i_count) == 16'h0000) && o_cycles == (o_taken ? CYC_JCZ_T : CYC_JCZ_NT))
    else $error("count zero jump");
  loop_cost_a: assert property (o_valid && o_class inside {CL_LOOP, CL_LOOP_Z, CL_LOOP_NZ} |->
    o_cycles == (o_taken ? CYC_LOOP_T : CYC_LOOP_NT)) else $error("loop cost");
  leave_one_byte_a: assert property (s_opc(OP_LEAVE) |=> o_valid && o_class == CL_LEAVE
    && o_cycles == CYC_LEAVE) else $error("leave decode");
  int_return_a: assert property (s_opc(OP_INT_RETURN) |=> o_valid && o_cycles == CYC_INT_RETURN)
    else $error("interrupt return decode");
  lock_prefix_a: assert property (s_opc(OP_LOCK) ##1 s_opc(OP_CARRY_SET) |=> o_valid && o_lock
    && o_cycles == CYC_FLAG_OP + ($past(i_bus8, 2) ? CYC_LOCK_8 : CYC_LOCK_16))
    else $error("lock prefix cost");
  escape_reg_a: assert property (o_valid && o_class == CL_COPROC_ESCAPE && o_rm_is_reg |->
    o_cycles == CYC_ESCAPE) else $error("escape cost");
  direct_addr_a: assert property (s_direct_mode ##1 i_byte_valid ##1 i_byte_valid |=>
    o_valid && o_eff_addr == {$past(i_byte), $past(i_byte, 2)}) else $error("direct address");
  string_dest_a: assert property (o_valid && $past(i_string_dest) |-> o_seg == SEG_EXTRA)
    else $error("string destination segment");
endmodule : ccx_decoder
`default_nettype wire

// ===== verification/ccx_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccx_fetch_model (
  input  wire logic       i_mclk,
  input  wire logic       i_slow,
  output logic [7:0]      o_byte,
  output logic            o_byte_valid
);
  logic [7:0] q[$];
  integer     seed = 32'h29ff62a5;

  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask : push

  initial begin
    o_byte = 8'h00;
    o_byte_valid = 1'b0;
  end

  // bytes leave low first in queue order; idle line shows a changing pattern
  always @(posedge i_mclk) begin
    #1;
    if (q.size() > 0 && !(i_slow && ($random(seed) & 3) == 0)) begin
      o_byte <= q.pop_front();
      o_byte_valid <= 1'b1;
    end else begin
      o_byte <= ~o_byte;
      o_byte_valid <= 1'b0;
    end
  end
endmodule : ccx_fetch_model
`default_nettype wire

// ===== verification/ccx_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ccx_decoder_tb;
  import ccx_pkg::*;
  typedef struct packed {
    ccx_class_type cls;
    logic [15:0]   cyc;
    logic          tk;
    logic [15:0]   disp;
    logic          ck;
    logic          mem;
    logic [15:0]   ea;
    logic [1:0]    seg;
    logic [5:0]    aux;
    logic [15:0]   imm;
    logic [7:0]    iv;
  } ccx_exp_type;
  logic          i_mclk, i_rstn, slow, bus8, wop, sdest, c, z, s, o, p, bval, t, pf, mem;
  logic [3:0]    xf;
  logic [1:0]    rr, o_seg;
  logic [15:0]   cnt, bx, si, di, bp, dw, o_cycles, o_disp, o_ea, o_imm;
  logic [7:0]    o_iv;
  logic [7:0]    byt, d, dh, m, op, lv;
  logic          o_valid, o_taken, o_eav, o_reg_high, o_rm_is_reg;
  logic [5:0]    o_esc;
  logic [2:0]    o_reg_idx;
  ccx_class_type o_class;
  ccx_exp_type   expq[$], ex, got;
  integer        seed = 32'h29ff62a5;
  int            error_cnt = 0, checked = 0, seen = 0, issued = 0, cyc_n = 0, n;
  logic [7:0]    fop[8] = '{8'hf8, 8'hf5, 8'hf9, 8'hfc, 8'hfd, 8'hfa, 8'hfb, 8'hf4};
  ccx_class_type fcl[8] = '{CL_CARRY_CLEAR, CL_CARRY_COMPL, CL_CARRY_SET, CL_DIR_CLEAR,
                            CL_DIR_SET, CL_IE_CLEAR, CL_IE_SET, CL_HALT};
  logic [7:0]    rop[4] = '{8'hc3, 8'hc2, 8'hcb, 8'hca};
  ccx_class_type rcl[4] = '{CL_RETURN_NEAR, CL_RETURN_NEAR_IMM, CL_RETURN_FAR, CL_RETURN_FAR_IMM};
  ccx_class_type lcl[4] = '{CL_JUMP_COUNT_ZERO, CL_LOOP, CL_LOOP_Z, CL_LOOP_NZ};
  int            r16[4] = '{16, 18, 22, 25};
  int            r8[4] = '{20, 22, 30, 33};

  ccx_fetch_model fm (.i_mclk(i_mclk), .i_slow(slow), .o_byte(byt), .o_byte_valid(bval));
  ccx_decoder uut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_byte(byt), .i_byte_valid(bval), .i_bus8(bus8),
    .i_word_op(wop), .i_string_dest(sdest), .i_mem_xfers(xf), .i_carry(c), .i_zero(z),
    .i_sign(s), .i_overflow(o), .i_parity(p), .i_count(cnt), .i_base(bx), .i_src_idx(si),
    .i_dst_idx(di), .i_frame(bp), .o_valid(o_valid), .o_class(o_class),
    .o_cycles(o_cycles), .o_taken(o_taken), .o_disp(o_disp), .o_imm(o_imm), .o_level(),
    .o_int_vector(o_iv), .o_eff_addr(o_ea), .o_eff_addr_valid(o_eav), .o_seg(o_seg),
    .o_lock(), .o_escape_code(o_esc), .o_reg_idx(o_reg_idx), .o_reg_high(o_reg_high),
    .o_rm_is_reg(o_rm_is_reg));

  function automatic ccx_exp_type mk(ccx_class_type k, int cy, logic tk, logic [15:0] ds);
    mk = '0;
    mk.cls = k;
    mk.cyc = 16'(cy);
    mk.tk = tk;
    mk.disp = ds;
  endfunction : mk

  function automatic logic jc(input logic [3:0] cc);
    logic r;
    case (cc[3:1])
      3'h0: r = o;
      3'h1: r = c;
      3'h2: r = z;
      3'h3: r = c | z;
      3'h4: r = s;
      3'h5: r = p;
      3'h6: r = s ^ o;
      default: r = (s ^ o) | z;
    endcase
    return r ^ cc[0];
  endfunction : jc

  function automatic logic [15:0] eaf(input logic [7:0] mb);
    case (mb[2:0])
      3'h0: return bx + si;
      3'h1: return bx + di;
      3'h2: return bp + si;
      3'h3: return bp + di;
      3'h4: return si;
      3'h5: return di;
      3'h6: return (mb[7:6] == 2'b00) ? 16'h0000 : bp;
      default: return bx;
    endcase
  endfunction : eaf

  task automatic fail(input string msg);
    $display("unexpected at %0t: %s", $time, msg);
    error_cnt++;
  endtask : fail

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic put(input logic [7:0] b);
    fm.push(b);
  endtask : put

  task automatic go(input ccx_exp_type e);
    int w;
    w = 0;
    expq.push_back(e);
    issued++;
    while (seen != issued && w < 300) begin
      @(posedge i_mclk);
      #1;
      w++;
    end
    if (w == 300) fail("no decode result");
  endtask : go

  task automatic shuffle();
    {c, z, s, o, p, slow} = 6'($random(seed));
    cnt = 16'($random(seed));
    {bx, si, di, bp} = 64'({$random(seed), $random(seed)});
    d = 8'($random(seed));
  endtask : shuffle

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    cyc_n++;
    if (cyc_n == 30000) begin
      fail("run timed out");
      summarize();
    end
  end

  always @(negedge i_mclk) begin
    if (o_valid === 1'b1) begin
      seen++;
      checked++;
      if (expq.size() == 0) begin
        fail("result without a note");
      end else begin
        got = expq.pop_front();
        if (o_class !== got.cls || o_cycles !== got.cyc || o_taken !== got.tk ||
            o_disp !== got.disp)
          fail($sformatf("class %0d cycles %0d want %0d", o_class, o_cycles, got.cyc));
        if (o_imm !== got.imm || o_iv !== got.iv)
          fail($sformatf("imm %h vector %h want %h %h", o_imm, o_iv, got.imm, got.iv));
        if (got.ck && (o_eav !== got.mem || (got.mem && (o_ea !== got.ea || o_seg !== got.seg))
            || ((o_class == CL_COPROC_ESCAPE) ? o_esc
                : {1'b0, o_rm_is_reg, o_reg_high, o_reg_idx}) !== got.aux))
          fail($sformatf("address %h seg %0d want %h %0d", o_ea, o_seg, got.ea, got.seg));
      end
    end
  end

  initial begin
    {i_rstn, slow, bus8, wop, sdest, c, z, s, o, p, xf, cnt, bx, si, di, bp} = '0;
    repeat (2) @(posedge i_mclk);
    #1 i_rstn = 1'b1;
    @(posedge i_mclk);
    #1;
    for (int k = 0; k < 8; k++) begin
      shuffle();
      put(fop[k]);
      go(mk(fcl[k], 2, 1'b0, 16'h0000));
    end
    for (int k = 0; k < 8; k++) begin
      bus8 = k[2];
      slow = k[1];
      put(rop[k[1:0]]);
      if (k[0]) put(d);
      if (k[0]) put(d);
      ex = mk(rcl[k[1:0]], bus8 ? r8[k[1:0]] : r16[k[1:0]], 1'b0, 16'h0000);
      if (k[0]) {ex.imm, ex.iv} = {d, d, d};
      go(ex);
      put(OP_LOCK);
      put(OP_CARRY_SET);
      go(mk(CL_CARRY_SET, bus8 ? 5 : 4, 1'b0, 16'h0000));
    end
    $display("flag, return and lock tests done");
    for (int k = 0; k < 28; k++) begin
      shuffle();
      if (k < 16) put(8'h70 | 8'(k));
      else put(8'he3 - 8'((k - 16) / 3));
      put(d);
      if (k < 16) go(mk(CL_JCC, jc(4'(k)) ? 13 : 4, jc(4'(k)), {{8{d[7]}}, d}));
      else begin
        if (k % 3 != 2) cnt = 16'(k % 3);
        t = (k < 19) ? (cnt == 0) : (cnt != 1 && (k < 22 || (k < 25 ? z : !z)));
        n = (k < 19) ? (t ? 15 : 5) : (t ? 16 : 6);
        go(mk(lcl[(k - 16) / 3], n, t, {{8{d[7]}}, d}));
      end
    end
    $display("branch tests done");
    for (int k = 0; k < 6; k++) begin
      shuffle();
      bus8 = k[0];
      o = k[1];
      lv = 8'((1 << (k / 2)) - 1);
      put(OP_ENTER);
      put(d);
      put(~d);
      put(lv);
      n = (lv == 0) ? 15 : (lv == 1) ? 25 : 22 + 16 * (lv - 1);
      ex = mk(CL_ENTER, bus8 ? n + 4 + ((lv > 1) ? 4 * (lv - 1) : 0) : n, 1'b0, 16'h0);
      {ex.imm, ex.iv} = {~d, d, d};
      go(ex);
      put(OP_LEAVE);
      go(mk(CL_LEAVE, 8, 1'b0, 16'h0000));
      put(OP_SOFT_INT);
      put(d);
      ex = mk(CL_SOFT_INT, 47, 1'b0, 16'h0000);
      {ex.imm, ex.iv} = {8'h00, d, d};
      go(ex);
      put(OP_BREAKPOINT);
      ex = mk(CL_BREAKPOINT, 45, 1'b0, 16'h0000);
      ex.iv = 8'h03;
      go(ex);
      put(OP_OVERFLOW_TRAP);
      ex = mk(CL_OVERFLOW_TRAP, o ? 48 : 4, o, 16'h0000);
      ex.iv = 8'h04;
      go(ex);
      put(OP_INT_RETURN);
      go(mk(CL_INT_RETURN, 28, 1'b0, 16'h0000));
    end
    $display("frame and interrupt tests done");
    for (int k = 0; k < 64; k++) begin
      shuffle();
      {bus8, wop, sdest, pf, xf, rr, m, dh} = 26'($random(seed));
      if (k < 16) m = {2'b00, m[5:3], 3'(k / 2)};
      op = k[0] ? OP_BOUND : {OP_ESCAPE_HIGH, 3'(k / 2)};
      mem = m[7:6] != 2'b11;
      dw = 16'h0000;
      if (pf) put({SEG_PFX_TOP, rr, SEG_PFX_LOW});
      put(op);
      put(m);
      if (m[7:6] == 2'b01) dw = {{8{d[7]}}, d};
      if (m[7:6] == 2'b10 || m[7:6] == 2'b01 || (m[7:6] == 2'b00 && m[2:0] == 3'h6)) put(d);
      if (m[7:6] == 2'b10 || (m[7:6] == 2'b00 && m[2:0] == 3'h6)) begin
        put(dh);
        dw = {dh, d};
      end
      n = (k[0] ? 35 : 6) + ((mem && bus8 && wop) ? 4 * xf : 0);
      ex = mk(k[0] ? CL_BOUND : CL_COPROC_ESCAPE, n, 1'b0, dw);
      ex.ck = 1'b1;
      ex.mem = mem;
      ex.ea = eaf(m) + dw;
      t = m[2:1] == 2'b01 || (m[2:0] == 3'h6 && m[7:6] != 2'b00);
      ex.seg = sdest ? SEG_EXTRA : pf ? rr : t ? SEG_STACK : SEG_DATA;
      ex.aux = {1'b0, !mem, wop ? {1'b0, m[5:3]} : {m[5], 1'b0, m[4:3]}};
      if (!k[0]) ex.aux = {op[2:0], m[5:3]};
      go(ex);
    end
    $display("operand address tests done");
    summarize();
  end
endmodule : ccx_decoder_tb
`default_nettype wire
